/* File: isr_defs.vh */
// Constants for the per-instance status reporting block.
// Assumes inclusion by bare name from the design modules.
`ifndef ISR_DEFS_VH
`define ISR_DEFS_VH

// ----------------------------------------------------------------------
// Register selectors on the command port
// ----------------------------------------------------------------------
`define ISR_SEL_LIMIT1 4'h0
`define ISR_SEL_LIMIT2 4'h1
`define ISR_SEL_LIMIT3 4'h2
`define ISR_SEL_LMASK1 4'h3
`define ISR_SEL_LMASK2 4'h4
`define ISR_SEL_LMASK3 4'h5
`define ISR_SEL_STDEV 4'h6
`define ISR_SEL_STMASK 4'h7
`define ISR_SEL_EXERR 4'h8
`define ISR_SEL_STATUS 4'h9
`define ISR_SEL_SRMASK 4'ha
`define ISR_SEL_QERR 4'hb
`define ISR_SEL_POLL 4'hc

// ----------------------------------------------------------------------
// Standard event bit positions
// ----------------------------------------------------------------------
`define ISR_SE_PON 7
`define ISR_SE_CME 5
`define ISR_SE_EXE 4
`define ISR_SE_VTO 3
`define ISR_SE_QYE 2
`define ISR_SE_OPC 0
`define ISR_SE_LIVE 8'hbd

// ----------------------------------------------------------------------
// Status byte bit positions
// ----------------------------------------------------------------------
`define ISR_SB_MSS 6
`define ISR_SB_ESB 5
`define ISR_SB_MAV 4
`define ISR_SB_LIVE 8'h77

// ----------------------------------------------------------------------
// Limit event bits and reset values
// ----------------------------------------------------------------------
`define ISR_LIM_FAULT 6
`define ISR_LIM_OCP 3
`define ISR_LIM_OVP 2
`define ISR_LIM_CC 1
`define ISR_LIM_CV 0
`define ISR_LIM_LIVE 8'h4f
`define ISR_RST_STDEV 8'h80
`define ISR_RST_ZERO 8'h00

// ----------------------------------------------------------------------
// Error codes and timing
// ----------------------------------------------------------------------
`define ISR_ERR_NONE 8'h00
`define ISR_ERR_RANGE 8'h64
`define ISR_ERR_EMPTY 8'h66
`define ISR_ERR_INVALID 8'h67
`define ISR_ERR_RCHG 8'h68
`define ISR_ERR_DENIED 8'hc8
`define ISR_QE_INTR 8'h01
`define ISR_QE_DEADLOCK 8'h02
`define ISR_QE_UNTERM 8'h03
`define ISR_VERIFY_MS 5000
`define ISR_CLK_MHZ 100
`endif

/* File: isr_limit_regs.v */
// Limit event register and its enable mask for one output.
// Assumes limit events arrive as one-cycle pulses on clk_i.
`timescale 1ns/1ps
`include "isr_defs.vh"
module isr_limit_regs (
    input wire clk_i,
    input wire rst_i,
    input wire [7:0] evt_i,
    input wire rd_clr_i,
    input wire mask_wr_i,
    input wire [7:0] mask_i,
    output reg [7:0] events_o,
    output reg [7:0] mask_o,
    output wire summary_o
);
    // ------------------------------------------------------------------
    // Events and mask
    // ------------------------------------------------------------------
    // New events win over the read clear so no trip is lost.
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            events_o <= `ISR_RST_ZERO;
            mask_o <= `ISR_RST_ZERO;
        end
        else
        begin
            events_o <= ((rd_clr_i ? 8'h00 : events_o) | evt_i)
                & `ISR_LIM_LIVE;
            if (mask_wr_i)
                mask_o <= mask_i;
        end
    end

    assign summary_o = |(events_o & mask_o);
endmodule // isr_limit_regs

/* File: isr_verify_timer.v */
// Verify timeout counter for one interface instance.
// Assumes start and reached are one-cycle pulses on clk_i.
`timescale 1ns/1ps
`include "isr_defs.vh"
module isr_verify_timer #(
    parameter integer TIMEOUT_CYCLES = `ISR_VERIFY_MS * 1000 *
        `ISR_CLK_MHZ
) (
    input wire clk_i,
    input wire rst_i,
    input wire start_i,
    input wire reached_i,
    output reg timeout_o
);
    reg [31:0] cnt_q;
    reg busy_q;

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cnt_q <= 32'h0;
            busy_q <= 1'b0;
            timeout_o <= 1'b0;
        end
        else
        begin
            timeout_o <= 1'b0;
            if (start_i)
            begin
                busy_q <= 1'b1;
                cnt_q <= 32'h0;
            end
            else if (busy_q && reached_i)
                busy_q <= 1'b0;
            else if (busy_q)
            begin
                if (cnt_q == TIMEOUT_CYCLES - 1)
                begin
                    busy_q <= 1'b0;
                    timeout_o <= 1'b1;
                end
                else
                    cnt_q <= cnt_q + 32'h1;
            end
        end
    end
endmodule // isr_verify_timer

/* File: isr_status_core.v */
// Status and error reporting for all interface instances.
// Assumes a command parser that issues one-cycle strobes per instance
// and reads query data one cycle after the read strobe.
`timescale 1ns/1ps
`include "isr_defs.vh"
module isr_status_core #(
    parameter integer NUM_INST = 6,
    parameter integer VERIFY_CYCLES = `ISR_VERIFY_MS * 1000 *
        `ISR_CLK_MHZ
) (
    input wire clk_i,
    input wire rst_i,
    input wire [2:0] inst_i,
    input wire rd_i,
    input wire wr_i,
    input wire [3:0] sel_i,
    input wire [7:0] wdata_i,
    output reg [7:0] rdata_o,
    output reg rvalid_o,
    input wire syntax_err_i,
    output wire parser_reset_o,
    input wire exec_err_i,
    input wire [7:0] exec_code_i,
    input wire range_fail_i,
    input wire verify_start_i,
    input wire verify_reached_i,
    input wire opc_i,
    input wire [1:0] query_err_i,
    input wire resp_ready_i,
    input wire resp_term_sent_i,
    input wire [7:0] out1_evt_i,
    input wire [7:0] out2_evt_i,
    input wire [7:0] out3_evt_i,
    output wire [NUM_INST-1:0] srq_o
);
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function strobe;
        input [2:0] inst;
        input integer idx;
        input en;
        begin
            strobe = en && (inst == idx[2:0]);
        end
    endfunction

    // Syntax errors restart the parser right away.
    assign parser_reset_o = syntax_err_i;

    wire [7:0] lev [0:NUM_INST*3-1];
    wire [7:0] lmk [0:NUM_INST*3-1];
    wire [NUM_INST*3-1:0] lsum;
    reg [7:0] stdev_q [0:NUM_INST-1];
    reg [7:0] stmask_q [0:NUM_INST-1];
    reg [7:0] exerr_q [0:NUM_INST-1];
    reg [7:0] srmask_q [0:NUM_INST-1];
    reg [7:0] qerr_q [0:NUM_INST-1];
    reg [NUM_INST-1:0] mav_q;
    reg [NUM_INST-1:0] rqs_q;
    reg [NUM_INST-1:0] mss_prev_q;
    wire [NUM_INST-1:0] vto;
    wire [7:0] sbyte [0:NUM_INST-1];
    wire [NUM_INST-1:0] mss;

    genvar g;
    generate
        for (g = 0; g < NUM_INST; g = g + 1)
        begin : inst_g
            // ----------------------------------------------------------
            // Per-instance limit registers and timer
            // ----------------------------------------------------------
            // Limit events are physical, so every instance sees them.
            isr_limit_regs u_out1 (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .evt_i(out1_evt_i),
                .rd_clr_i(strobe(inst_i, g, rd_i) &&
                    sel_i == `ISR_SEL_LIMIT1),
                .mask_wr_i(strobe(inst_i, g, wr_i) &&
                    sel_i == `ISR_SEL_LMASK1),
                .mask_i(wdata_i),
                .events_o(lev[g*3]),
                .mask_o(lmk[g*3]),
                .summary_o(lsum[g*3])
            );
            isr_limit_regs u_out2 (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .evt_i(out2_evt_i),
                .rd_clr_i(strobe(inst_i, g, rd_i) &&
                    sel_i == `ISR_SEL_LIMIT2),
                .mask_wr_i(strobe(inst_i, g, wr_i) &&
                    sel_i == `ISR_SEL_LMASK2),
                .mask_i(wdata_i),
                .events_o(lev[g*3+1]),
                .mask_o(lmk[g*3+1]),
                .summary_o(lsum[g*3+1])
            );
            isr_limit_regs u_out3 (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .evt_i(out3_evt_i),
                .rd_clr_i(strobe(inst_i, g, rd_i) &&
                    sel_i == `ISR_SEL_LIMIT3),
                .mask_wr_i(strobe(inst_i, g, wr_i) &&
                    sel_i == `ISR_SEL_LMASK3),
                .mask_i(wdata_i),
                .events_o(lev[g*3+2]),
                .mask_o(lmk[g*3+2]),
                .summary_o(lsum[g*3+2])
            );
            isr_verify_timer #(
                .TIMEOUT_CYCLES(VERIFY_CYCLES)
            ) u_vt (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .start_i(strobe(inst_i, g, verify_start_i)),
                .reached_i(strobe(inst_i, g, verify_reached_i)),
                .timeout_o(vto[g])
            );

            // ----------------------------------------------------------
            // Status byte, combinational from current contents
            // ----------------------------------------------------------
            wire esb = |(stdev_q[g] & stmask_q[g]);
            wire [7:0] pre = {1'b0, 1'b0, esb, mav_q[g], 1'b0,
                lsum[g*3+2], lsum[g*3+1], lsum[g*3]};
            assign mss[g] = |(pre & srmask_q[g] & 8'hbf);
            assign sbyte[g] = (pre | {1'b0, mss[g], 6'h00})
                & (`ISR_SB_LIVE | 8'h40);
            assign srq_o[g] = rqs_q[g];

            wire rd_g = strobe(inst_i, g, rd_i);
            wire wr_g = strobe(inst_i, g, wr_i);
            wire err_g = strobe(inst_i, g, exec_err_i);
            wire rng_g = strobe(inst_i, g, range_fail_i);
            wire qe_g = strobe(inst_i, g, |query_err_i);
            wire [7:0] code_g = rng_g ? `ISR_ERR_RCHG : exec_code_i;
            wire load_g = err_g || rng_g;
            wire [7:0] sev;
            assign sev[`ISR_SE_PON] = 1'b0;
            assign sev[6] = 1'b0;
            assign sev[`ISR_SE_CME] = strobe(inst_i, g, syntax_err_i);
            assign sev[`ISR_SE_EXE] = load_g &&
                code_g != `ISR_ERR_NONE;
            assign sev[`ISR_SE_VTO] = vto[g];
            assign sev[`ISR_SE_QYE] = qe_g;
            assign sev[1] = 1'b0;
            assign sev[`ISR_SE_OPC] = strobe(inst_i, g, opc_i);

            // ----------------------------------------------------------
            // Per-instance registers
            // ----------------------------------------------------------
            always @(posedge clk_i or posedge rst_i)
            begin
                if (rst_i)
                begin
                    stdev_q[g] <= `ISR_RST_STDEV;
                    stmask_q[g] <= `ISR_RST_ZERO;
                    exerr_q[g] <= `ISR_RST_ZERO;
                    srmask_q[g] <= `ISR_RST_ZERO;
                    qerr_q[g] <= `ISR_RST_ZERO;
                    mav_q[g] <= 1'b0;
                    rqs_q[g] <= 1'b0;
                    mss_prev_q[g] <= 1'b0;
                end
                else
                begin
                    // Events set in the clear cycle survive the clear.
                    stdev_q[g] <= (((rd_g && sel_i == `ISR_SEL_STDEV)
                        ? 8'h00 : stdev_q[g]) | sev)
                        & `ISR_SE_LIVE;
                    if (load_g)
                        exerr_q[g] <= code_g;
                    else if (rd_g && sel_i == `ISR_SEL_EXERR)
                        exerr_q[g] <= `ISR_ERR_NONE;
                    if (qe_g)
                        qerr_q[g] <= {6'h00, query_err_i};
                    else if (rd_g && sel_i == `ISR_SEL_QERR)
                        qerr_q[g] <= `ISR_RST_ZERO;
                    if (wr_g && sel_i == `ISR_SEL_STMASK)
                        stmask_q[g] <= wdata_i;
                    if (wr_g && sel_i == `ISR_SEL_SRMASK)
                        srmask_q[g] <= wdata_i;
                    if (strobe(inst_i, g, resp_ready_i))
                        mav_q[g] <= 1'b1;
                    else if (strobe(inst_i, g, resp_term_sent_i))
                        mav_q[g] <= 1'b0;
                    mss_prev_q[g] <= mss[g];
                    // A new rise of the summary wins over a poll.
                    if (mss[g] && !mss_prev_q[g])
                        rqs_q[g] <= 1'b1;
                    else if (rd_g && sel_i == `ISR_SEL_POLL)
                        rqs_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Read data path
    // ------------------------------------------------------------------
    // Query data shows the value before any clear-on-read takes effect.
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdata_o <= 8'h00;
            rvalid_o <= 1'b0;
        end
        else
        begin
            rvalid_o <= rd_i;
            // Instances without a register set answer zero, never unknown.
            if (rd_i && inst_i >= NUM_INST)
                rdata_o <= 8'h00;
            else if (rd_i)
            begin
                case (sel_i)
                    `ISR_SEL_LIMIT1: rdata_o <= lev[inst_i*3];
                    `ISR_SEL_LIMIT2: rdata_o <= lev[inst_i*3+1];
                    `ISR_SEL_LIMIT3: rdata_o <= lev[inst_i*3+2];
                    `ISR_SEL_LMASK1: rdata_o <= lmk[inst_i*3];
                    `ISR_SEL_LMASK2: rdata_o <= lmk[inst_i*3+1];
                    `ISR_SEL_LMASK3: rdata_o <= lmk[inst_i*3+2];
                    `ISR_SEL_STDEV: rdata_o <= stdev_q[inst_i];
                    `ISR_SEL_STMASK: rdata_o <= stmask_q[inst_i];
                    `ISR_SEL_EXERR: rdata_o <= exerr_q[inst_i];
                    `ISR_SEL_STATUS: rdata_o <= sbyte[inst_i];
                    `ISR_SEL_SRMASK: rdata_o <= srmask_q[inst_i];
                    `ISR_SEL_QERR: rdata_o <= qerr_q[inst_i];
                    `ISR_SEL_POLL: rdata_o <= {sbyte[inst_i][7],
                        rqs_q[inst_i], sbyte[inst_i][5:0]};
                    default: rdata_o <= 8'h00;
                endcase
            end
        end
    end
endmodule // isr_status_core

/* File: isr_status_core_chk.sv */
// Port checker for the status reporting core.
// Assumes one clock domain and the core's async active-high reset.
`timescale 1ns/1ps
`include "isr_defs.vh"
module isr_status_chk #(
    parameter integer NUM_INST = 6,
    parameter integer VERIFY_CYCLES = 20
) (
    input wire clk_i,
    input wire rst_i,
    input wire [2:0] inst_i,
    input wire rd_i,
    input wire [3:0] sel_i,
    input wire [7:0] rdata_o,
    input wire rvalid_o,
    input wire syntax_err_i,
    input wire parser_reset_o,
    input wire exec_err_i,
    input wire [7:0] exec_code_i,
    input wire range_fail_i,
    input wire [NUM_INST-1:0] srq_o
);
// ----------------------------------------------------------------------
// Properties
// ----------------------------------------------------------------------
default clocking @(posedge clk_i); endclocking
default disable iff (rst_i);
// A quiet cycle keeps a stray load or read from hiding the code under test.
sequence s_quiet;
    !exec_err_i && !range_fail_i && !rd_i;
endsequence
sequence s_eer_rd;
    rd_i && sel_i == `ISR_SEL_EXERR && inst_i == 3'd0 && !exec_err_i &&
    !range_fail_i;
endsequence
a_read_answer: assert property (rd_i |=> rvalid_o)
    else $error("read not answered");
a_answer_cause: assert property (!$past(rd_i) |-> !rvalid_o)
    else $error("answer without read");
a_parser_restart: assert property (parser_reset_o == syntax_err_i)
    else $error("parser restart mismatch");
a_stdev_zeros: assert property (rd_i && sel_i == `ISR_SEL_STDEV
    |=> !rdata_o[6] && !rdata_o[1]) else $error("unused event bit set");
a_status_zeros: assert property (rd_i && sel_i == `ISR_SEL_STATUS
    |=> !rdata_o[7] && !rdata_o[3]) else $error("unused status bit set");
a_limit_resvd: assert property (rd_i && sel_i <= `ISR_SEL_LIMIT3
    |=> (rdata_o & 8'hb0) == 8'h00) else $error("reserved limit bit set");
a_exec_code: assert property ((exec_err_i && !range_fail_i &&
    inst_i == 3'd0) ##1 s_quiet ##1 s_eer_rd
    |=> rdata_o == $past(exec_code_i, 3)) else $error("error code lost");
a_range_code: assert property ((range_fail_i && inst_i == 3'd0)
    ##1 s_quiet ##1 s_eer_rd |=> rdata_o == `ISR_ERR_RCHG)
    else $error("range change code wrong");
a_exerr_clears: assert property (s_eer_rd ##1 s_quiet ##1 s_eer_rd
    |=> rdata_o == 8'h00) else $error("error code not cleared");
a_srq_hold: assert property (srq_o[0] && !(rd_i &&
    sel_i == `ISR_SEL_POLL && inst_i == 3'd0) |=> srq_o[0])
    else $error("request flag dropped unpolled");
endmodule // isr_status_chk

bind isr_status_core isr_status_chk #(.NUM_INST(NUM_INST),
    .VERIFY_CYCLES(VERIFY_CYCLES)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .inst_i(inst_i), .rd_i(rd_i), .sel_i(sel_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .syntax_err_i(syntax_err_i),
    .parser_reset_o(parser_reset_o), .exec_err_i(exec_err_i),
    .exec_code_i(exec_code_i), .range_fail_i(range_fail_i), .srq_o(srq_o));

/* File: isr_ctl_model.sv */
// Remote controller model issuing queries and writes per instance.
// Assumes the core answers every query exactly one cycle later.
`timescale 1ns/1ps
module isr_ctl_model (
    input wire clk_i,
    input wire [7:0] rdata_i,
    input wire rvalid_i,
    output reg [2:0] inst_o,
    output reg rd_o,
    output reg wr_o,
    output reg [3:0] sel_o,
    output reg [7:0] wdata_o
);
// ----------------------------------------------------------------------
// Command tasks
// ----------------------------------------------------------------------
initial {inst_o, rd_o, wr_o, sel_o, wdata_o} = 17'h0;
task aim(input [2:0] i);
    inst_o = i;
endtask
// Idle write data is inverted so a stale byte is never taken for fresh.
task write(input [2:0] i, input [3:0] s, input [7:0] d);
begin
    @(posedge clk_i);
    #1;
    {inst_o, sel_o, wdata_o, wr_o} = {i, s, d, 1'b1};
    @(posedge clk_i);
    #1;
    {wdata_o, wr_o} = {~d, 1'b0};
end
endtask
task query(input [2:0] i, input [3:0] s, output [7:0] q, output ok);
begin
    @(posedge clk_i);
    #1;
    {inst_o, sel_o, rd_o} = {i, s, 1'b1};
    @(posedge clk_i);
    #1;
    rd_o = 1'b0;
    q = rdata_i;
    ok = (rvalid_i === 1'b1);
end
endtask
endmodule // isr_ctl_model

/* File: isr_status_core_bench.sv */
// Self-checking bench for the status reporting core.
// Assumes the controller model and the bound port checker.
`timescale 1ns/1ps
`include "isr_defs.vh"
module isr_status_core_bench;
localparam [7:0] SYN = 8'h01, EXE = 8'h02, RNG = 8'h04, OPC = 8'h08;
localparam [7:0] RDY = 8'h10, TRM = 8'h20, VST = 8'h40, VRE = 8'h80;
reg clk_i = 1'b0;
reg rst_i = 1'b1;
reg [7:0] strb, code;
reg [1:0] qerr;
reg [23:0] lim;
wire [2:0] inst;
wire rd, wr, rvalid;
wire [3:0] sel;
wire [7:0] wdata, rdata;
wire [5:0] srq;
integer error_cnt = 0;
integer num_checks = 0;
always #5 clk_i = ~clk_i;
isr_status_core #(.NUM_INST(6), .VERIFY_CYCLES(20)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .inst_i(inst), .rd_i(rd), .wr_i(wr),
    .sel_i(sel), .wdata_i(wdata), .rdata_o(rdata), .rvalid_o(rvalid),
    .syntax_err_i(strb[0]), .parser_reset_o(), .exec_err_i(strb[1]),
    .exec_code_i(code), .range_fail_i(strb[2]), .verify_start_i(strb[6]),
    .verify_reached_i(strb[7]), .opc_i(strb[3]), .query_err_i(qerr),
    .resp_ready_i(strb[4]), .resp_term_sent_i(strb[5]),
    .out1_evt_i(lim[7:0]), .out2_evt_i(lim[15:8]), .out3_evt_i(lim[23:16]),
    .srq_o(srq));
isr_ctl_model u_ctl (.clk_i(clk_i), .rdata_i(rdata), .rvalid_i(rvalid),
    .inst_o(inst), .rd_o(rd), .wr_o(wr), .sel_o(sel), .wdata_o(wdata));
// ----------------------------------------------------------------------
// Shared tasks
// ----------------------------------------------------------------------
task results;
begin
    if (error_cnt == 0 && num_checks > 0)
        $display("All tests passed");
    else
        $display("Some tests failed");
    $finish;
end
endtask
task chk(input string nm, input [7:0] got, input [7:0] exp);
begin
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
        error_cnt = error_cnt + 1;
        $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
end
endtask
task rq(input [2:0] i, input [3:0] s, input [7:0] exp);
    reg [7:0] q;
    reg ok;
begin
    u_ctl.query(i, s, q, ok);
    chk("answer valid", {7'h0, ok}, 8'h01);
    chk($sformatf("reg %h inst %0d", s, i), q, exp);
end
endtask
task pulse(input [2:0] i, input [7:0] s, input [7:0] c, input [1:0] qe);
begin
    @(posedge clk_i);
    #1;
    u_ctl.aim(i);
    {strb, code, qerr} = {s, c, qe};
    @(posedge clk_i);
    #1;
    {strb, code, qerr} = {8'h00, ~c, 2'h0};
end
endtask
task limits(input [7:0] a, input [7:0] b, input [7:0] c);
begin
    @(posedge clk_i);
    #1;
    lim = {c, b, a};
    @(posedge clk_i);
    #1;
    lim = 24'h0;
end
endtask
// ----------------------------------------------------------------------
// Scenarios
// ----------------------------------------------------------------------
task t_reset;
    integer i;
begin
    for (i = 0; i < 6; i = i + 1)
    begin
        rq(i[2:0], `ISR_SEL_STDEV, `ISR_RST_STDEV);
        rq(i[2:0], `ISR_SEL_STDEV, 8'h00);
        rq(i[2:0], `ISR_SEL_EXERR, 8'h00);
        rq(i[2:0], `ISR_SEL_STMASK, 8'h00);
    end
    rq(3'd6, `ISR_SEL_STDEV, 8'h00);
end
endtask
task t_stdev;
begin
    pulse(3'd1, SYN | EXE | OPC, `ISR_ERR_RANGE, 2'd3);
    pulse(3'd1, VST, 8'h00, 2'd0);
    pulse(3'd4, VST, 8'h00, 2'd0);
    pulse(3'd4, VRE, 8'h00, 2'd0);
    repeat (30) @(posedge clk_i);
    rq(3'd1, `ISR_SEL_STDEV, 8'h3d);
    rq(3'd1, `ISR_SEL_QERR, `ISR_QE_UNTERM);
    rq(3'd1, `ISR_SEL_EXERR, `ISR_ERR_RANGE);
    rq(3'd4, `ISR_SEL_STDEV, 8'h00);
    rq(3'd0, `ISR_SEL_STDEV, 8'h00);
end
endtask
task t_codes;
    integer k;
    reg [7:0] c;
begin
    for (k = 0; k < 4; k = k + 1)
    begin
        c = (k == 0) ? `ISR_ERR_RANGE : (k == 1) ? `ISR_ERR_EMPTY :
            (k == 2) ? `ISR_ERR_INVALID : `ISR_ERR_DENIED;
        pulse(3'd0, EXE, c, 2'd0);
        rq(3'd0, `ISR_SEL_EXERR, c);
        rq(3'd0, `ISR_SEL_EXERR, 8'h00);
        pulse(3'd2, 8'h00, 8'h00, k[1:0]);
        rq(3'd2, `ISR_SEL_QERR, {6'h0, k[1:0]});
    end
    pulse(3'd0, EXE | RNG, `ISR_ERR_DENIED, 2'd0);
    rq(3'd0, `ISR_SEL_EXERR, `ISR_ERR_RCHG);
    rq(3'd0, `ISR_SEL_STDEV, 8'h10);
    pulse(3'd0, EXE, `ISR_ERR_NONE, 2'd0);
    rq(3'd0, `ISR_SEL_STDEV, 8'h00);
    rq(3'd2, `ISR_SEL_STDEV, 8'h04);
end
endtask
task t_limit;
begin
    u_ctl.write(3'd2, `ISR_SEL_LMASK1, 8'h40);
    u_ctl.write(3'd2, `ISR_SEL_LMASK2, 8'h08);
    u_ctl.write(3'd2, `ISR_SEL_LMASK3, 8'h04);
    limits(8'hff, 8'h08, 8'h04);
    rq(3'd2, `ISR_SEL_STATUS, 8'h07);
    rq(3'd2, `ISR_SEL_LMASK3, 8'h04);
    rq(3'd2, `ISR_SEL_LIMIT1, `ISR_LIM_LIVE);
    rq(3'd2, `ISR_SEL_STATUS, 8'h06);
    rq(3'd2, `ISR_SEL_LIMIT2, 8'h08);
    rq(3'd2, `ISR_SEL_LIMIT3, 8'h04);
    rq(3'd2, `ISR_SEL_LIMIT1, 8'h00);
    rq(3'd2, `ISR_SEL_STATUS, 8'h00);
    rq(3'd5, `ISR_SEL_LIMIT1, `ISR_LIM_LIVE);
end
endtask
task t_summary;
begin
    u_ctl.write(3'd0, `ISR_SEL_STMASK, 8'h10);
    pulse(3'd0, EXE, `ISR_ERR_EMPTY, 2'd0);
    rq(3'd0, `ISR_SEL_STATUS, 8'h20);
    u_ctl.write(3'd0, `ISR_SEL_STMASK, 8'hef);
    rq(3'd0, `ISR_SEL_STMASK, 8'hef);
    rq(3'd0, `ISR_SEL_STATUS, 8'h00);
    u_ctl.write(3'd0, `ISR_SEL_STMASK, 8'h10);
    u_ctl.write(3'd0, `ISR_SEL_SRMASK, 8'h20);
    rq(3'd0, `ISR_SEL_SRMASK, 8'h20);
    rq(3'd0, `ISR_SEL_STATUS, 8'h60);
    chk("request flags", {2'h0, srq}, 8'h01);
    rq(3'd0, `ISR_SEL_POLL, 8'h60);
    chk("request flag", {7'h0, srq[0]}, 8'h00);
    rq(3'd0, `ISR_SEL_POLL, 8'h20);
    rq(3'd0, `ISR_SEL_STATUS, 8'h60);
    rq(3'd0, `ISR_SEL_STDEV, 8'h10);
    rq(3'd0, `ISR_SEL_STATUS, 8'h00);
end
endtask
task t_mav;
begin
    pulse(3'd3, RDY, 8'h00, 2'd0);
    rq(3'd3, `ISR_SEL_STATUS, 8'h10);
    pulse(3'd3, TRM, 8'h00, 2'd0);
    rq(3'd3, `ISR_SEL_STATUS, 8'h00);
end
endtask
// ----------------------------------------------------------------------
// Main sequence and watchdog
// ----------------------------------------------------------------------
initial
begin
    {strb, code, qerr, lim} = 42'h0;
    repeat (8) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    t_reset;
    t_stdev;
    t_codes;
    t_limit;
    t_summary;
    t_mav;
    results;
end
initial
begin
    repeat (20000) @(posedge clk_i);
    error_cnt = error_cnt + 1;
    results;
end
endmodule // isr_status_core_bench
